// *** rtl/vrpc_pkg.sv ***
package vrpc_pkg;
	localparam logic REF_SEL_EXTERNAL = 1'b0;
	localparam logic REF_SEL_INTERNAL = 1'b1;
	localparam logic AUTOZERO_RST = 1'b1;
	localparam logic REF_SEL_RST = 1'b0;
	localparam int AZ_PHASE_W = 2;
	typedef enum logic [1:0] {
		VRPC_ADC_SHUTDOWN = 2'b00,
		VRPC_ADC_STANDBY = 2'b10,
		VRPC_ADC_CONVERT = 2'b11
	} vrpc_adcmode_e;
	typedef enum logic [1:0] {
		VRPC_POR = 2'b00,
		VRPC_RUN = 2'b01
	} vrpc_state_e;
endpackage

// *** rtl/vrpc_sync.sv ***
`timescale 1ns/1ns
module vrpc_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic asyncIn,
	output logic syncOut
);
	logic stage1Q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1Q <= 1'b0;
			syncOut <= 1'b0;
		end else if (clkEn) begin
			stage1Q <= asyncIn;
			syncOut <= stage1Q;
		end
	end
endmodule

// *** rtl/vrpc_top.sv ***
// Contract
// RQ1 - Select 0: external reference, buffer off, input
// RQ2 - Select 1: internal reference, pin driven output
// RQ3 - Buffer powered in standby or conversion only
// RQ4 - Auto-zero runs on modulator clock, gated
// RQ5 - Auto-zero enable resets to one
// RQ6 - Host keeps auto-zero on above OSR 256
// RQ7 - Low supply: POR, SPI off, defaults
// RQ8 - Leave POR only when both supplies good
// RQ9 - Chip select rise resets SPI interface; code only releases spiReset, set in POR, once select is high
// RQ10 - Chip select fall clears POR interrupt
// RQ11 - Full shutdown ignores monitors, except brownout
// RQ12 - POR exit sets interrupt until cleared
`timescale 1ns/1ns
module vrpc_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic avddGood,
	input wire logic dvddGood,
	input wire logic supplyCritical,
	input wire logic fullShutdown,
	input wire logic modClkTick,
	input wire logic chipSelN,
	input wire logic refSelWr,
	input wire logic refSelWrData,
	input wire logic autozeroWr,
	input wire logic autozeroWrData,
	input wire vrpc_pkg::vrpc_adcmode_e adcMode,
	output logic refSel,
	output logic referenceAutozeroEnable,
	output logic refBufPower,
	output logic refPinOutEn,
	output logic autozeroPhase,
	output logic spiEnable,
	output logic registerDefaults,
	output logic spiReset,
	output logic porIrqN
);
	import vrpc_pkg::*;

	logic avddS, dvddS, critS, csS;
	vrpc_state_e stateQ, stateD;
	logic csPrevQ;
	logic porFlagQ;
	logic [AZ_PHASE_W-1:0] azCountQ;

	// One decode for buffer and pad direction; the buffer is further gated by ADC mode, so it stays off in shutdown while the pad drives
	function automatic logic refDrivenOut(input logic sel, input logic por);
		return (sel == REF_SEL_INTERNAL) && !por;
	endfunction

	vrpc_sync uAvdd (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .asyncIn(avddGood),
		.syncOut(avddS));
	vrpc_sync uDvdd (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .asyncIn(dvddGood),
		.syncOut(dvddS));
	vrpc_sync uCrit (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .asyncIn(supplyCritical),
		.syncOut(critS));
	vrpc_sync uCs (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .asyncIn(chipSelN),
		.syncOut(csS));

	// Monitors are blind in full shutdown; only a deep brownout still trips
	wire suppliesBad = fullShutdown ? critS : (!avddS || !dvddS || critS); // RQ7 RQ11
	wire suppliesUp = avddS && dvddS && !critS; // RQ8
	wire inPor = (stateQ == VRPC_POR);
	wire csRise = csS && !csPrevQ;
	wire csFall = !csS && csPrevQ;
	wire csClear = csFall && !inPor; // RQ10
	wire porExit = inPor && (stateD == VRPC_RUN);
	wire bufAllowed = (adcMode == VRPC_ADC_STANDBY) || (adcMode == VRPC_ADC_CONVERT);
	wire refSelD = inPor ? REF_SEL_RST : (refSelWr ? refSelWrData : refSel);
	wire azEnD = inPor ? AUTOZERO_RST : (autozeroWr ? autozeroWrData : referenceAutozeroEnable);
	wire pinOutD = refDrivenOut(refSel, inPor); // RQ1 RQ2
	wire bufOnD = refDrivenOut(refSel, inPor) && bufAllowed; // RQ1 RQ2 RQ3
	wire azRunD = bufOnD && referenceAutozeroEnable; // RQ4

	always_comb begin
		stateD = stateQ;
		unique case (stateQ)
			VRPC_POR: if (suppliesUp) stateD = VRPC_RUN;
			VRPC_RUN: if (suppliesBad) stateD = VRPC_POR;
			default: stateD = VRPC_POR;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateQ <= VRPC_POR;
			csPrevQ <= 1'b1;
		end else if (clkEn) begin
			stateQ <= stateD; // RQ7 RQ8
			csPrevQ <= csS;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			refSel <= REF_SEL_RST;
			referenceAutozeroEnable <= AUTOZERO_RST;
		end else if (clkEn) begin
			refSel <= refSelD; // RQ7
			referenceAutozeroEnable <= azEnD; // RQ5
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			refBufPower <= 1'b0;
			refPinOutEn <= 1'b0;
		end else if (clkEn) begin
			refBufPower <= bufOnD; // RQ3
			refPinOutEn <= pinOutD; // RQ1 RQ2
		end
	end

	// Phase advances only on modulator ticks so chopping stays locked to it
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			azCountQ <= '0;
			autozeroPhase <= 1'b0;
		end else if (clkEn) begin
			if (!azRunD) begin
				azCountQ <= '0;
				autozeroPhase <= 1'b0;
			end else if (modClkTick) begin
				azCountQ <= azCountQ + 1'b1;
				autozeroPhase <= azCountQ[AZ_PHASE_W-1]; // RQ4
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			spiEnable <= 1'b0;
			registerDefaults <= 1'b1;
			spiReset <= 1'b1;
			porFlagQ <= 1'b0;
			porIrqN <= 1'b1;
		end else if (clkEn) begin
			spiEnable <= (stateD == VRPC_RUN); // RQ7 RQ8
			registerDefaults <= (stateD == VRPC_POR); // RQ7
			// SPI stays in reset from POR until chip select is seen high
			if (inPor)
				spiReset <= 1'b1;
			else if (csRise || csS)
				spiReset <= 1'b0; // RQ9
			// Set beats clear in the same cycle
			if (porExit)
				porFlagQ <= 1'b1; // RQ12
			else if (csClear)
				porFlagQ <= 1'b0; // RQ10
			porIrqN <= !(porExit || (porFlagQ && !csClear)); // RQ10 RQ12
		end
	end

	a_spi_off_por: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		inPor |-> !spiEnable) else $error("SPI enabled during POR");
	a_defaults_por: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && inPor && (stateD == VRPC_POR) |=> registerDefaults && !refSel
		&& referenceAutozeroEnable) else $error("Defaults not held in POR");
	a_exit_both_good: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && inPor && !(avddS && dvddS) |=> inPor) else $error("POR left early");
	a_ext_pin_input: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
		clkEn && refSel == REF_SEL_EXTERNAL |=> !refPinOutEn && !refBufPower)
		else $error("External ref but pin driven");
	a_int_pin_output: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
		clkEn && refSel && !inPor |=> refPinOutEn) else $error("Internal ref not driven");
	a_buf_shutdown: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		clkEn && adcMode == VRPC_ADC_SHUTDOWN |=> !refBufPower)
		else $error("Buffer on in shutdown");
	a_az_gated: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
		clkEn && !referenceAutozeroEnable |=> !autozeroPhase)
		else $error("Auto-zero ran while disabled");
	a_irq_on_exit: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
		clkEn && porExit |=> !porIrqN) else $error("No interrupt on POR exit");
	a_irq_cs_clear: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
		clkEn && csClear && !porExit |=> porIrqN ##1 (porIrqN || !clkEn || !inPor))
		else $error("Interrupt not cleared by chip select");
	a_shutdown_ignore: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
		clkEn && !inPor && fullShutdown && !critS |=> !inPor)
		else $error("POR in full shutdown");

	a_az_por_one: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
		clkEn && inPor |=> referenceAutozeroEnable) else $error("Auto-zero enable not default");
	a_az_write_zero: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
		clkEn && !inPor && autozeroWr && !autozeroWrData |=> !referenceAutozeroEnable)
		else $error("Auto-zero enable clear lost");
	a_az_write_one: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
		clkEn && !inPor && autozeroWr && autozeroWrData |=> referenceAutozeroEnable)
		else $error("Auto-zero enable set lost");
	a_az_tick_only: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
		clkEn && azRunD && !modClkTick |=> $stable(autozeroPhase))
		else $error("Auto-zero phase moved off a tick");
	a_ref_por_off: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && inPor |=> !refBufPower && !refPinOutEn) else $error("Reference driven in POR");
	a_ref_write_one: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
		clkEn && !inPor && refSelWr && refSelWrData |=> refSel) else $error("Select set lost");
	a_ref_write_zero: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
		clkEn && !inPor && refSelWr && !refSelWrData |=> !refSel)
		else $error("Select clear lost");
	a_buf_on_mode: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
		clkEn && bufAllowed && refSel && !inPor |=> refBufPower)
		else $error("Buffer off in standby or conversion");
	a_por_on_low: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
		clkEn && !inPor && !fullShutdown && !(avddS && dvddS) |=> inPor)
		else $error("Low supply missed");
	a_por_on_crit: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
		clkEn && critS |=> inPor) else $error("Critical supply missed");
	a_spi_on_run: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && !inPor && !suppliesBad |=> spiEnable) else $error("SPI off while running");
	a_regdef_run: assert property (@(posedge clk) disable iff (sys_rst) // RQ8
		clkEn && !inPor && !suppliesBad |=> !registerDefaults)
		else $error("Defaults forced while running");

	a_spi_rst_por: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		clkEn && inPor |=> spiReset) else $error("SPI reset released in POR");
	a_spi_rst_hold: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		clkEn && !inPor && !csS |=> $stable(spiReset))
		else $error("SPI reset moved while select low");
	a_spi_rst_free: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
		clkEn && !inPor && csS |=> !spiReset) else $error("SPI reset not released");
	a_irq_idle_high: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
		clkEn && !porExit && !porFlagQ |=> porIrqN) else $error("Interrupt without POR exit");
	a_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
		clkEn && porExit |=> porFlagQ) else $error("POR flag not set");
	a_flag_cs_clear: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
		clkEn && csClear && !porExit |=> !porFlagQ) else $error("POR flag not cleared");
	a_irq_stays_low: assert property (@(posedge clk) disable iff (sys_rst) // RQ12
		clkEn && porFlagQ && !csClear |=> !porIrqN) else $error("Interrupt dropped early");
endmodule

// *** bench/vrpc_host_model.sv ***
`timescale 1ns/1ns
module vrpc_host_model (
	input wire logic clk,
	output logic avddGood,
	output logic dvddGood,
	output logic chipSelN
);
	initial begin
		avddGood = 1'b0;
		dvddGood = 1'b0;
		chipSelN = 1'b0;
	end
	task automatic supply(input logic av, input logic dv);
		@(posedge clk);
		avddGood <= av;
		dvddGood <= dv;
	endtask
	// Select held low through POR, so a high pulse must come first
	task automatic select(input logic lvl);
		@(posedge clk);
		chipSelN <= lvl;
	endtask
endmodule

// *** bench/vrpc_top_bench.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module vrpc_top_bench;
	import vrpc_pkg::*;
	logic clk = 1'b0, sysRst = 1'b1, crit = 1'b0, fsd = 1'b0, tick = 1'b0, en = 1'b1, p;
	logic rsWr = 1'b0, rsD = 1'b0, azWr = 1'b0, azD = 1'b0;
	vrpc_adcmode_e mode = VRPC_ADC_SHUTDOWN;
	logic avdd, dvdd, csN, refSel, azEn, bufPwr, pinOe, phase, spiEn, regDef, spiRst, irqN;
	int fail_count = 0, check_count = 0;
	always #5 clk = ~clk;
	vrpc_host_model u_vrpc_host_model (.clk(clk), .avddGood(avdd), .dvddGood(dvdd),
		.chipSelN(csN));
	vrpc_top u_vrpc_top (.clk(clk), .sys_rst(sysRst), .clkEn(en), .avddGood(avdd),
		.dvddGood(dvdd), .supplyCritical(crit), .fullShutdown(fsd), .modClkTick(tick),
		.chipSelN(csN), .refSelWr(rsWr), .refSelWrData(rsD), .autozeroWr(azWr),
		.autozeroWrData(azD), .adcMode(mode), .refSel(refSel),
		.referenceAutozeroEnable(azEn), .refBufPower(bufPwr), .refPinOutEn(pinOe),
		.autozeroPhase(phase), .spiEnable(spiEn), .registerDefaults(regDef),
		.spiReset(spiRst), .porIrqN(irqN));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic az, input logic d);
		@(posedge clk);
		azWr <= az;
		rsWr <= !az;
		azD <= d;
		rsD <= d;
		@(posedge clk);
		azWr <= 1'b0;
		rsWr <= 1'b0;
		cyc(3);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		cyc(2);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		results();
	end
	initial begin
		repeat (8) @(posedge clk);
		sysRst <= 1'b0;
		cyc(2);
		`CHK("azEn", 1'b1, azEn)
		`CHK("regDef", 1'b1, regDef)
		wr(1'b0, 1'b1);
		`CHK("refSel in POR", 1'b0, refSel)
		u_vrpc_host_model.supply(1'b1, 1'b0);
		cyc(6);
		`CHK("spiEn one supply", 1'b0, spiEn)
		u_vrpc_host_model.supply(1'b1, 1'b1);
		cyc(4);
		`CHK("spiEn", 1'b1, spiEn)
		`CHK("regDef run", 1'b0, regDef)
		`CHK("irqN set", 1'b0, irqN)
		`CHK("spiRst held", 1'b1, spiRst)
		u_vrpc_host_model.select(1'b1);
		cyc(5);
		`CHK("spiRst", 1'b0, spiRst)
		`CHK("irqN kept", 1'b0, irqN)
		u_vrpc_host_model.select(1'b0);
		cyc(5);
		`CHK("irqN clear", 1'b1, irqN)
		for (int s = 0; s < 2; s++) begin
			wr(1'b0, s[0]);
			for (int m = 0; m < 3; m++) begin
				@(posedge clk);
				mode <= m == 0 ? VRPC_ADC_SHUTDOWN : m == 1 ? VRPC_ADC_STANDBY : VRPC_ADC_CONVERT;
				cyc(3);
				`CHK("refSel", s[0], refSel)
				`CHK("pinOe", s[0], pinOe)
				`CHK("bufPwr", s[0] && m > 0, bufPwr)
			end
		end
		@(posedge clk);
		en <= 1'b0;
		wr(1'b0, 1'b0);
		`CHK("refSel frozen", 1'b1, refSel)
		@(posedge clk);
		en <= 1'b1;
		wr(1'b1, 1'b0);
		`CHK("azEn off", 1'b0, azEn)
		p = phase;
		ticks(4);
		`CHK("phase held", p, phase)
		wr(1'b1, 1'b1);
		p = phase;
		ticks(3);
		`CHK("phase moved", ~p, phase)
		@(posedge clk);
		fsd <= 1'b1;
		u_vrpc_host_model.supply(1'b0, 1'b0);
		cyc(6);
		`CHK("spiEn shutdown", 1'b1, spiEn)
		@(posedge clk);
		crit <= 1'b1;
		cyc(6);
		`CHK("spiEn critical", 1'b0, spiEn)
		`CHK("refSel default", 1'b0, refSel)
		results();
	end
endmodule
